// *** hdl/dtc_pkg.sv ***
// Constants shared by the dual timer/counter pair: register indices, fields, resets.
// Assumes a 40 MHz core clock and a register bus with 32-bit aligned words.
package dtc_pkg;

    // Core clock and machine cycle framing
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          PHASES        = 12;        // Core clocks per machine cycle
    localparam logic [3:0]  SAMPLE_PHASE  = 4'h9;      // Fifth state, second phase
    localparam logic [3:0]  UPDATE_PHASE  = 4'h4;      // Third state, first phase
    localparam int          EDGE_CLOCKS   = 2 * PHASES; // Clocks to recognise one fall

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL      = 8'h88;
    localparam logic [7:0]  IDX_MODE      = 8'h89;
    localparam logic [7:0]  IDX_LO_A      = 8'h8A;
    localparam logic [7:0]  IDX_LO_B      = 8'h8B;
    localparam logic [7:0]  IDX_HI_A      = 8'h8C;
    localparam logic [7:0]  IDX_HI_B      = 8'h8D;
    localparam logic [7:0]  IDX_IRQ_ST    = 8'h90;
    localparam logic [7:0]  IDX_IRQ_MASK  = 8'h91;

    // Mode register fields
    localparam int          MODE_GATE_B   = 7;
    localparam int          MODE_CT_B     = 6;
    localparam int          MODE_SEL_B    = 4;         // Two bits, lsb position
    localparam int          MODE_GATE_A   = 3;
    localparam int          MODE_CT_A     = 2;
    localparam int          MODE_SEL_A    = 0;

    // Control register fields
    localparam int          CTRL_FLAG_B   = 7;
    localparam int          CTRL_RUN_B    = 6;
    localparam int          CTRL_FLAG_A   = 5;
    localparam int          CTRL_RUN_A    = 4;

    // Interrupt status fields
    localparam int          IRQ_OVF_A     = 0;
    localparam int          IRQ_OVF_B     = 1;

    // Reset values
    localparam logic [7:0]  RST_MODE      = 8'h00;
    localparam logic [7:0]  RST_CTRL      = 8'h00;
    localparam logic [7:0]  RST_COUNT     = 8'h00;
    localparam logic [1:0]  RST_IRQ       = 2'h0;

    // Bus responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        DTC_M13   = 2'h0,
        DTC_M16   = 2'h1,
        DTC_M8AR  = 2'h2,
        DTC_MSPL  = 2'h3
    } dtc_mode_t;

endpackage : dtc_pkg

// *** hdl/dtc_pin_if.sv ***
// Interface between the timer core and its pin sampler.
// Assumes both ends run on the one core clock.
interface dtc_pin_if #(
    parameter int N = 4
);
    logic [N-1:0] raw;     // Asynchronous pin levels
    logic         stb;     // Sample strobe, once per machine cycle
    logic [N-1:0] level;   // Synchronised levels
    logic [N-1:0] fall;    // One-cycle pulse after a sampled high-to-low

    modport smp (input raw, input stb, output level, output fall);
    modport core (output raw, output stb, input level, input fall);
endinterface : dtc_pin_if

// *** hdl/dtc_pin_sampler.sv ***
// Pin synchroniser and once-per-machine-cycle falling edge detector.
// Assumes the strobe is a single-cycle pulse from the core clock domain.
module dtc_pin_sampler (
    input  wire logic clk_sys,
    input  wire logic rst,
    dtc_pin_if.smp    pins
);

    localparam int N = $bits(pins.raw);

    logic [N-1:0] sync1_r;
    logic [N-1:0] sync2_r;
    logic [N-1:0] last_r;
    logic [N-1:0] fall_r;

    // Two-stage synchroniser
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins.raw;
            sync2_r <= sync1_r;
        end
    end

    // High in one sample, low in the next
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            last_r <= '0;
            fall_r <= '0;
        end else begin
            fall_r <= '0;
            if (pins.stb) begin
                last_r <= sync2_r;
                fall_r <= last_r & ~sync2_r;
            end
        end
    end

    assign pins.level = sync2_r;
    assign pins.fall  = fall_r;

    a_fall_at_sample: assert property (@(posedge clk_sys) disable iff (rst)
        (fall_r != '0) |-> $past(pins.stb))
        else $error("edge reported outside the sample phase");

endmodule : dtc_pin_sampler

// *** hdl/dtc_timer_pair.sv ***
// Two timer/counters with modes 13-bit, 16-bit, 8-bit reload and split/stop.
// Assumes an AXI4-Lite master on clk_sys and asynchronous count and gate pins.

module dtc_timer_pair #(
    parameter int ADDR_W = 12
) (
    input  wire  logic              clk_sys,
    input  wire  logic              rst,
    input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire  logic              s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire  logic [31:0]       s_axi_wdata,
    input  wire  logic [3:0]        s_axi_wstrb,
    input  wire  logic              s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire  logic              s_axi_bready,
    input  wire  logic [ADDR_W-1:0] s_axi_araddr,
    input  wire  logic              s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire  logic              s_axi_rready,
    input  wire  logic              count_pin_a,
    input  wire  logic              count_pin_b,
    input  wire  logic              gate_pin_a,
    input  wire  logic              gate_pin_b,
    output logic                    irq
);

    if (ADDR_W < 11) begin : g_chk
        $error("ADDR_W too small for the register map");
    end

    // Register index of a byte address; returns all ones when not word aligned
    function automatic logic [7:0] dtc_index(input logic [ADDR_W-1:0] a);
        if (a[1:0] != 2'h0 || a[ADDR_W-1:10] != '0) begin
            return 8'hFF;
        end
        return a[9:2];
    endfunction : dtc_index

    // One count step of a cascaded pair: {overflow, high, low}
    function automatic logic [16:0] dtc_step(input logic [1:0] m,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo);
        case (m)
            dtc_pkg::DTC_M13: begin
                if (lo[4:0] == 5'h1F) begin
                    return {hi == 8'hFF, hi + 8'h01, lo[7:5], 5'h00};
                end
                return {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
            end
            dtc_pkg::DTC_M16: return {1'b0, hi, lo} + 17'h00001;
            dtc_pkg::DTC_M8AR: begin
                if (lo == 8'hFF) begin
                    return {1'b1, hi, hi};
                end
                return {1'b0, hi, lo + 8'h01};
            end
            default: return {1'b0, hi, lo};
        endcase
    endfunction : dtc_step

    logic [3:0]  phase_r;
    logic [7:0]  mode_r;
    logic [7:0]  ctrl_r;
    logic [7:0]  lo_a_r;
    logic [7:0]  hi_a_r;
    logic [7:0]  lo_b_r;
    logic [7:0]  hi_b_r;
    logic        pend_a_r;
    logic        pend_b_r;
    logic [1:0]  irq_st_r;
    logic [1:0]  irq_mask_r;
    logic        aw_full_r;
    logic        w_full_r;
    logic [7:0]  aw_idx_r;
    logic [7:0]  w_data_r;
    logic        w_lane_r;

    dtc_pin_if #(.N(4)) pin_bus ();

    dtc_pin_sampler u_sampler (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pins    (pin_bus)
    );

    // Pins: bit 0 count a, 1 count b, 2 gate a, 3 gate b
    assign pin_bus.raw = {gate_pin_b, gate_pin_a, count_pin_b, count_pin_a};
    assign pin_bus.stb = (phase_r == dtc_pkg::SAMPLE_PHASE);

    // Machine cycle phase, twelve core clocks
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_r <= 4'h0;
        end else if (phase_r == 4'(dtc_pkg::PHASES - 1)) begin
            phase_r <= 4'h0;
        end else begin
            phase_r <= phase_r + 4'h1;
        end
    end

    // Bus handshake terms
    logic       aw_acc;
    logic       w_acc;
    logic       ar_acc;
    logic       do_wr;
    logic       wr_en;
    logic [7:0] ar_idx;

    assign aw_acc = s_axi_awvalid & s_axi_awready;
    assign w_acc  = s_axi_wvalid & s_axi_wready;
    assign ar_acc = s_axi_arvalid & s_axi_arready;
    assign do_wr  = aw_full_r & w_full_r & ~s_axi_bvalid;
    assign wr_en  = do_wr & w_lane_r;
    assign ar_idx = dtc_index(s_axi_araddr);

    // Write address and data are latched in either order
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            aw_idx_r      <= 8'h00;
            w_data_r      <= 8'h00;
            w_lane_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            if (aw_acc) begin
                aw_full_r <= 1'b1;
                aw_idx_r  <= dtc_index(s_axi_awaddr);
            end else if (do_wr) begin
                aw_full_r <= 1'b0;
            end
            if (w_acc) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata[7:0];
                w_lane_r <= s_axi_wstrb[0];
            end else if (do_wr) begin
                w_full_r <= 1'b0;
            end
            s_axi_awready <= ~aw_full_r & ~aw_acc & ~s_axi_bvalid & ~do_wr;
            s_axi_wready  <= ~w_full_r & ~w_acc & ~s_axi_bvalid & ~do_wr;
        end
    end

    // Write response
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dtc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            case (aw_idx_r)
                dtc_pkg::IDX_CTRL, dtc_pkg::IDX_MODE, dtc_pkg::IDX_LO_A,
                dtc_pkg::IDX_LO_B, dtc_pkg::IDX_HI_A, dtc_pkg::IDX_HI_B,
                dtc_pkg::IDX_IRQ_ST, dtc_pkg::IDX_IRQ_MASK: begin
                    s_axi_bresp <= dtc_pkg::RESP_OKAY;
                end
                default: s_axi_bresp <= dtc_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Mode register, whole byte writes only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_r <= dtc_pkg::RST_MODE;
        end else if (wr_en && aw_idx_r == dtc_pkg::IDX_MODE) begin
            mode_r <= w_data_r;
        end
    end

    // Decoded configuration
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic       split;
    logic       en_a;
    logic       en_b;
    logic       upd;
    logic       tick_a;
    logic       tick_ah;
    logic       tick_b;
    logic [16:0] step_a;
    logic [16:0] step_b;
    logic       ovf_a;
    logic       ovf_b;

    assign mode_a = mode_r[dtc_pkg::MODE_SEL_A +: 2];
    assign mode_b = mode_r[dtc_pkg::MODE_SEL_B +: 2];
    assign split  = (mode_a == dtc_pkg::DTC_MSPL);
    assign upd    = (phase_r == dtc_pkg::UPDATE_PHASE);

    // Run and gate qualification
    assign en_a = ctrl_r[dtc_pkg::CTRL_RUN_A]
                & (~mode_r[dtc_pkg::MODE_GATE_A] | pin_bus.level[2]);
    assign en_b = (split | ctrl_r[dtc_pkg::CTRL_RUN_B])
                & (~mode_r[dtc_pkg::MODE_GATE_B] | pin_bus.level[3]);

    // Source select: pending pin edge or every machine cycle
    assign tick_a  = upd & en_a & (~mode_r[dtc_pkg::MODE_CT_A] | pend_a_r);
    assign tick_b  = upd & en_b & (~mode_r[dtc_pkg::MODE_CT_B] | pend_b_r);
    assign tick_ah = upd & split & ctrl_r[dtc_pkg::CTRL_RUN_B];

    assign step_a = dtc_step(mode_a, hi_a_r, lo_a_r);
    assign step_b = dtc_step(mode_b, hi_b_r, lo_b_r);

    // Overflow events of the two flags
    assign ovf_a = tick_a & (split ? (lo_a_r == 8'hFF) : step_a[16]);
    assign ovf_b = (tick_ah & (hi_a_r == 8'hFF)) | (tick_b & step_b[16] & ~split);

    // Edge waits in the sample cycle, counts at next update phase
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pend_a_r <= 1'b0;
            pend_b_r <= 1'b0;
        end else begin
            pend_a_r <= pin_bus.fall[0] | (pend_a_r & ~upd);
            pend_b_r <= pin_bus.fall[1] | (pend_b_r & ~upd);
        end
    end

    // Timer a counts; software writes override a same-cycle step
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lo_a_r <= dtc_pkg::RST_COUNT;
            hi_a_r <= dtc_pkg::RST_COUNT;
        end else begin
            if (tick_a) begin
                if (split) begin
                    lo_a_r <= lo_a_r + 8'h01;
                end else begin
                    {hi_a_r, lo_a_r} <= step_a[15:0];
                end
            end
            if (tick_ah) begin
                hi_a_r <= hi_a_r + 8'h01;
            end
            if (wr_en && aw_idx_r == dtc_pkg::IDX_LO_A) begin
                lo_a_r <= w_data_r;
            end
            if (wr_en && aw_idx_r == dtc_pkg::IDX_HI_A) begin
                hi_a_r <= w_data_r;
            end
        end
    end

    // Timer b counts
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lo_b_r <= dtc_pkg::RST_COUNT;
            hi_b_r <= dtc_pkg::RST_COUNT;
        end else begin
            if (tick_b) begin
                {hi_b_r, lo_b_r} <= step_b[15:0];
            end
            if (wr_en && aw_idx_r == dtc_pkg::IDX_LO_B) begin
                lo_b_r <= w_data_r;
            end
            if (wr_en && aw_idx_r == dtc_pkg::IDX_HI_B) begin
                hi_b_r <= w_data_r;
            end
        end
    end

    // Control register; an overflow wins over a clearing write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_r <= dtc_pkg::RST_CTRL;
        end else begin
            if (wr_en && aw_idx_r == dtc_pkg::IDX_CTRL) begin
                ctrl_r <= w_data_r;
            end
            if (ovf_a) begin
                ctrl_r[dtc_pkg::CTRL_FLAG_A] <= 1'b1;
            end
            if (ovf_b) begin
                ctrl_r[dtc_pkg::CTRL_FLAG_B] <= 1'b1;
            end
        end
    end

    // Sticky status, read clears, mask gates the interrupt
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_st_r   <= dtc_pkg::RST_IRQ;
            irq_mask_r <= dtc_pkg::RST_IRQ;
            irq        <= 1'b0;
        end else begin
            if (ar_acc && ar_idx == dtc_pkg::IDX_IRQ_ST) begin
                irq_st_r <= {ovf_b, ovf_a};
            end else begin
                irq_st_r <= irq_st_r | {ovf_b, ovf_a};
            end
            if (wr_en && aw_idx_r == dtc_pkg::IDX_IRQ_MASK) begin
                irq_mask_r <= w_data_r[1:0];
            end
            irq <= |(irq_st_r & irq_mask_r);
        end
    end

    // Read channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= dtc_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
        end else begin
            if (ar_acc) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= dtc_pkg::RESP_OKAY;
                case (ar_idx)
                    dtc_pkg::IDX_CTRL:     s_axi_rdata <= {24'h0, ctrl_r};
                    dtc_pkg::IDX_MODE:     s_axi_rdata <= {24'h0, mode_r};
                    dtc_pkg::IDX_LO_A:     s_axi_rdata <= {24'h0, lo_a_r};
                    dtc_pkg::IDX_LO_B:     s_axi_rdata <= {24'h0, lo_b_r};
                    dtc_pkg::IDX_HI_A:     s_axi_rdata <= {24'h0, hi_a_r};
                    dtc_pkg::IDX_HI_B:     s_axi_rdata <= {24'h0, hi_b_r};
                    dtc_pkg::IDX_IRQ_ST:   s_axi_rdata <= {30'h0, irq_st_r};
                    dtc_pkg::IDX_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_r};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= dtc_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= ~ar_acc & ~(s_axi_rvalid & ~s_axi_rready);
        end
    end

    a_timer_tick_phase: assert property (@(posedge clk_sys) disable iff (rst)
        upd |-> ##12 (phase_r == dtc_pkg::UPDATE_PHASE))
        else $error("machine cycle is not twelve core clocks");

    a_edge_update_lag: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(pend_a_r) |-> ##5 (phase_r == dtc_pkg::UPDATE_PHASE && pend_a_r))
        else $error("pin edge not held until the following update phase");

    a_gate_blocks_a: assert property (@(posedge clk_sys) disable iff (rst)
        (mode_r[dtc_pkg::MODE_GATE_A] && !pin_bus.level[2] && !do_wr && !tick_ah)
        |=> (lo_a_r == $past(lo_a_r) && hi_a_r == $past(hi_a_r)))
        else $error("gated timer a counted with gate pin low");

    a_mode16_incr: assert property (@(posedge clk_sys) disable iff (rst)
        (tick_a && mode_a == dtc_pkg::DTC_M16 && !do_wr)
        |=> {hi_a_r, lo_a_r} == $past({hi_a_r, lo_a_r}) + 16'h0001)
        else $error("sixteen-bit mode did not add one");

    a_reload_from_hi: assert property (@(posedge clk_sys) disable iff (rst)
        (tick_b && mode_b == dtc_pkg::DTC_M8AR && lo_b_r == 8'hFF && !do_wr)
        |=> (lo_b_r == hi_b_r && ctrl_r[dtc_pkg::CTRL_FLAG_B]))
        else $error("auto reload missed or flag not set");

    a_b_stopped_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (mode_b == dtc_pkg::DTC_MSPL && !do_wr)
        |=> ({hi_b_r, lo_b_r} == $past({hi_b_r, lo_b_r})))
        else $error("timer b moved while stopped");

    a_prescale_carry: assert property (@(posedge clk_sys) disable iff (rst)
        (tick_a && mode_a == dtc_pkg::DTC_M13 && lo_a_r[4:0] == 5'h1F && !do_wr)
        |=> (lo_a_r[4:0] == 5'h00 && hi_a_r == $past(hi_a_r) + 8'h01))
        else $error("prescaler carry did not reach the high byte");

    a_ovf_sets_flag: assert property (@(posedge clk_sys) disable iff (rst)
        ovf_a |=> ctrl_r[dtc_pkg::CTRL_FLAG_A] && irq_st_r[dtc_pkg::IRQ_OVF_A])
        else $error("overflow of timer a not flagged");

    a_irq_follows: assert property (@(posedge clk_sys) disable iff (rst)
        (|(irq_st_r & irq_mask_r)) |=> irq)
        else $error("interrupt not raised for unmasked status");

endmodule : dtc_timer_pair

// *** bench/dtc_pin_model.sv ***
// Outside world of the timer pair: count and gate pins.
// Assumes callers step it from the core clock domain.
module dtc_pin_model #(
    parameter int HOLD = 12
) (
    input  wire logic clk_sys,
    output logic      count_pin_a,
    output logic      count_pin_b,
    output logic      gate_pin_a,
    output logic      gate_pin_b
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels, pins pulled up
    initial begin
        count_pin_a = 1'b1;
        count_pin_b = 1'b1;
        gate_pin_a  = 1'b1;
        gate_pin_b  = 1'b1;
    end

    // Falls on pin b (on_b high) or pin a, each level held one machine cycle
    task automatic pulses(input logic on_b, input int n);
        for (int i = 0; i < n; i++) begin
            count_pin_a <= on_b;
            count_pin_b <= ~on_b;
            repeat (HOLD) @(posedge clk_sys);
            count_pin_a <= 1'b1;
            count_pin_b <= 1'b1;
            repeat (HOLD) @(posedge clk_sys);
        end
    endtask : pulses

    // Gate levels of both timers
    task automatic gates(input logic va, input logic vb);
        gate_pin_a <= va;
        gate_pin_b <= vb;
    endtask : gates
endmodule : dtc_pin_model

// *** bench/test_dual_timer_counter_pair.sv ***
// Self-checking bench for the timer pair over AXI4-Lite.
// Assumes dtc_pkg, the design and dtc_pin_model are compiled first.
module test_dual_timer_counter_pair;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic [11:0] awaddr  = 12'h0;
    logic [11:0] araddr  = 12'h0;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq, cpa, cpb, gpa, gpb;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          errors = 0, check_count = 0, cyc = 0;

    dtc_timer_pair #(.ADDR_W(12)) u_dtc_timer_pair (
        .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .count_pin_a(cpa), .count_pin_b(cpb), .gate_pin_a(gpa), .gate_pin_b(gpb),
        .irq(irq));
    dtc_pin_model u_dtc_pin_model (.clk_sys(clk_sys), .count_pin_a(cpa),
        .count_pin_b(cpb), .gate_pin_a(gpa), .gate_pin_b(gpb));

    // 40 MHz core clock
    always #12.5 clk_sys = ~clk_sys;

    // Cycle count and hang limit
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end

    // Verdict and end of run
    task automatic end_sim();
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // Register write, address and data offered together
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
        logic a_done, w_done;
        a_done = 1'b0;
        w_done = 1'b0;
        awaddr  <= {2'h0, idx, 2'h0};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(a_done && w_done)) begin
            @(posedge clk_sys);
            if (awvalid && awready) begin
                a_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk_sys); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        @(posedge clk_sys);
    endtask : wr

    // Register read
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        araddr  <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask : rd

    // Read and compare data and response
    task automatic rc(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er = 2'h0);
        logic [31:0] d;
        logic [1:0]  r;
        rd(idx, d, r);
        check(d, {24'h0, e});
        check({30'h0, r}, {30'h0, er});
    endtask : rc

    // Machine-cycle rate, run bit keeps the counts
    task automatic t_rate();
        logic [31:0] v0, v1;
        logic [1:0]  r;
        int          t0;
        wr(dtc_pkg::IDX_MODE, 8'h01);
        wr(dtc_pkg::IDX_HI_A, 8'h5A);
        wr(dtc_pkg::IDX_CTRL, 8'h10);
        t0 = cyc;
        rd(dtc_pkg::IDX_LO_A, v0, r);
        wait (cyc == t0 + 121);
        rd(dtc_pkg::IDX_LO_A, v1, r);
        check(v1 - v0, 32'hA);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
        rc(dtc_pkg::IDX_HI_A, 8'h5A);
    endtask : t_rate

    // Prescaled mode, overflow flag and interrupt
    task automatic t_presc();
        int n;
        wr(dtc_pkg::IDX_MODE, 8'h00);
        wr(dtc_pkg::IDX_HI_A, 8'hFF);
        wr(dtc_pkg::IDX_LO_A, 8'h1E);
        wr(dtc_pkg::IDX_IRQ_MASK, 8'h01);
        wr(dtc_pkg::IDX_CTRL, 8'h10);
        for (n = 0; n < 100 && irq !== 1'b1; n++) @(posedge clk_sys);
        check({31'h0, irq}, 32'h1);
        rc(dtc_pkg::IDX_CTRL, 8'h30);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
        rc(dtc_pkg::IDX_CTRL, 8'h00);
        rc(dtc_pkg::IDX_HI_A, 8'h00);
        rc(dtc_pkg::IDX_IRQ_ST, 8'h01);
        rc(dtc_pkg::IDX_IRQ_ST, 8'h00);
        check({31'h0, irq}, 32'h0);
    endtask : t_presc

    // Auto-reload with the interrupt masked
    task automatic t_reload();
        logic [31:0] v;
        logic [1:0]  r;
        wr(dtc_pkg::IDX_IRQ_MASK, 8'h00);
        wr(dtc_pkg::IDX_MODE, 8'h22);
        wr(dtc_pkg::IDX_HI_A, 8'hF0);
        wr(dtc_pkg::IDX_LO_A, 8'hFE);
        wr(dtc_pkg::IDX_HI_B, 8'hF0);
        wr(dtc_pkg::IDX_LO_B, 8'hFE);
        wr(dtc_pkg::IDX_CTRL, 8'h50);
        repeat (60) @(posedge clk_sys);
        check({31'h0, irq}, 32'h0);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
        rc(dtc_pkg::IDX_HI_A, 8'hF0);
        rd(dtc_pkg::IDX_LO_A, v, r);
        check(v & 32'hF8, 32'hF0);
        rc(dtc_pkg::IDX_HI_B, 8'hF0);
        rd(dtc_pkg::IDX_LO_B, v, r);
        check(v & 32'hF8, 32'hF0);
        rc(dtc_pkg::IDX_IRQ_ST, 8'h03);
    endtask : t_reload

    // Pin edges at top rate, gate, then stopped mode
    task automatic t_count();
        wr(dtc_pkg::IDX_MODE, 8'hD0);
        wr(dtc_pkg::IDX_LO_B, 8'h00);
        u_dtc_pin_model.gates(1'b1, 1'b1);
        wr(dtc_pkg::IDX_CTRL, 8'h40);
        u_dtc_pin_model.pulses(1'b1, 5);
        repeat (48) @(posedge clk_sys);
        u_dtc_pin_model.gates(1'b1, 1'b0);
        u_dtc_pin_model.pulses(1'b1, 3);
        repeat (48) @(posedge clk_sys);
        rc(dtc_pkg::IDX_LO_B, 8'h05);
        wr(dtc_pkg::IDX_MODE, 8'h70);
        u_dtc_pin_model.pulses(1'b1, 3);
        repeat (48) @(posedge clk_sys);
        rc(dtc_pkg::IDX_LO_B, 8'h05);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
    endtask : t_count

    // Timer a counts pin edges only while its gate pin is high
    task automatic t_gate();
        wr(dtc_pkg::IDX_MODE, 8'h0D);
        wr(dtc_pkg::IDX_LO_A, 8'h00);
        u_dtc_pin_model.gates(1'b0, 1'b1);
        wr(dtc_pkg::IDX_CTRL, 8'h10);
        u_dtc_pin_model.pulses(1'b0, 2);
        repeat (48) @(posedge clk_sys);
        u_dtc_pin_model.gates(1'b1, 1'b1);
        u_dtc_pin_model.pulses(1'b0, 3);
        repeat (48) @(posedge clk_sys);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
        rc(dtc_pkg::IDX_LO_A, 8'h03);
    endtask : t_gate

    // Split timer a: high half runs and flags on the run bit of timer b
    task automatic t_split();
        wr(dtc_pkg::IDX_MODE, 8'h03);
        wr(dtc_pkg::IDX_LO_A, 8'h77);
        wr(dtc_pkg::IDX_HI_A, 8'hFE);
        wr(dtc_pkg::IDX_CTRL, 8'h40);
        repeat (36) @(posedge clk_sys);
        rc(dtc_pkg::IDX_CTRL, 8'hC0);
        wr(dtc_pkg::IDX_CTRL, 8'h00);
        rc(dtc_pkg::IDX_LO_A, 8'h77);
    endtask : t_split

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rc(dtc_pkg::IDX_MODE, 8'h00);
        rc(dtc_pkg::IDX_CTRL, 8'h00);
        t_rate();
        t_presc();
        t_reload();
        t_count();
        t_gate();
        t_split();
        rc(8'hA0, 8'h00, dtc_pkg::RESP_SLVERR);
        wr(8'hA0, 8'h55, dtc_pkg::RESP_SLVERR);
        wstrb <= 4'h0;
        wr(dtc_pkg::IDX_HI_B, 8'hAA);
        wstrb <= 4'hF;
        rc(dtc_pkg::IDX_HI_B, 8'hF0);
        end_sim();
    end
endmodule : test_dual_timer_counter_pair
